// ==== verilog/admrs_pkg.sv ====
// Constants and carrier types for the converter channel and reference select block.
package admrs_pkg;

  // ==========================================================================
  // Register map: the printed register offset is an index, the byte address is four times it.
  localparam logic [7:0] CRR_INDEX = 8'h07;
  localparam logic [7:0] CRR_ADDR = {CRR_INDEX[5:0], 2'b00};
  localparam logic [7:0] CTLB_ADDR = 8'h20;
  localparam logic [7:0] CONV_ADDR = 8'h24;
  localparam logic [7:0] RES_ADDR = 8'h28;

  // ==========================================================================
  // Field positions.
  localparam int CRR_REF_HI = 7;
  localparam int CRR_REF_LO = 6;
  localparam int CRR_JUST_BIT = 5;
  localparam int CRR_CHAN_HI = 4;
  localparam int CTLB_CHAN_X_BIT = 0;
  localparam int CTLB_REF_X_BIT = 1;
  localparam int CONV_START_BIT = 0;
  localparam int CONV_DONE_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_LONG_BIT = 2;
  localparam int STAT_REF_LO = 4;
  localparam int STAT_CHAN_LO = 8;

  // ==========================================================================
  // Reset values.
  localparam logic [7:0] CRR_RESET = 8'h00;
  localparam logic [1:0] CTLB_RESET = 2'h0;

  // ==========================================================================
  // Timing and channel codes.
  localparam int RES_W = 10;
  localparam int NORMAL_CONV_CYCLES = 13;
  localparam int EXTENDED_CONV_CYCLES = 25;
  localparam logic [5:0] LAST_SE_CHAN = 6'h0A;
  localparam logic [5:0] TEMP_CHAN = 6'h0B;
  localparam logic [3:0] TEMP_INPUT = 4'hB;

  // ==========================================================================
  // Carrier types.
  typedef enum logic [1:0] {GAIN_1X, GAIN_8X, GAIN_20X, GAIN_32X} admrs_gain_t;

  typedef struct packed {
    logic supply;
    logic ext_pin;
    logic int_1v1;
    logic int_2v56;
    logic bypass_cap;
  } admrs_ref_t;

  typedef struct packed {
    logic single_ended;
    logic differential;
    logic temp_en;
    logic [3:0] pos;
    logic [3:0] neg;
    admrs_gain_t gain;
  } admrs_route_t;

endpackage : admrs_pkg

// ==== verilog/admrs_top.sv ====
// Channel, reference and result-justify select logic of the converter, with an AHB-Lite register slave.
`timescale 1ns/1ps

// Operation
// - Reference code low bits 00 pick the supply cut off from the reference pin, 01 pick the reference pin with the internal reference off, whatever the extra bit.
// - Extra bit 0 with bits 10 picks the internal 1.1 V reference, and 0 with 11 is reserved for software.
// - Extra bit 1 with bits 10 picks the internal 2.56 V reference cut off from the pin, and with 11 the same reference with its bypass capacitor on the pin.
// - A reference write during a conversion takes effect only once that conversion ends and its done flag sets.
// - After any change of the reference bits the next conversion lasts 25 converter clock cycles.
// - Result justify 1 shows the result left aligned in the result word, 0 shows it right aligned.
// - Writing the justify bit realigns the visible result at once, even during a conversion.
// - The five channel bits and the extra channel bit of control register B form one six-bit code choosing inputs and gain.
// - Some channel codes route one pin to both differential inputs for offset measurement.
// - Single-ended channel eleven enables the temperature sensor and routes it to the converter.
// - A channel write during a conversion takes effect only once that conversion ends and its done flag sets.

module admrs_top #(
  parameter int NORMAL_CYCLES = admrs_pkg::NORMAL_CONV_CYCLES,
  parameter int EXTENDED_CYCLES = admrs_pkg::EXTENDED_CONV_CYCLES
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_i,
  // AHB-Lite slave.
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Analog front end.
  input wire logic [admrs_pkg::RES_W-1:0] conv_result_i,
  output admrs_pkg::admrs_ref_t ref_sel_o,
  output admrs_pkg::admrs_route_t route_o,
  output logic converting_o
);

  localparam int CW = $clog2(EXTENDED_CYCLES + 1);
  localparam logic [CW-1:0] NORMAL_LOAD = CW'(NORMAL_CYCLES - 1);
  localparam logic [CW-1:0] EXTENDED_LOAD = CW'(EXTENDED_CYCLES - 1);

  // A conversion must last at least two cycles and the extended one must not be shorter.
  if (NORMAL_CYCLES < 2 || EXTENDED_CYCLES < NORMAL_CYCLES) begin : g_bad_cycles
    $error("admrs_top: conversion cycle counts out of range");
  end

  // ==========================================================================
  // Decoding functions.

  function automatic admrs_pkg::admrs_ref_t decode_ref(input logic [2:0] code);
    admrs_pkg::admrs_ref_t r;
    r = '0;
    case (code[1:0])
      2'b00: r.supply = 1'b1;
      2'b01: r.ext_pin = 1'b1;
      2'b10: begin
        if (code[2]) begin
          r.int_2v56 = 1'b1;
        end else begin
          r.int_1v1 = 1'b1;
        end
      end
      default: begin
        if (code[2]) begin
          r.int_2v56 = 1'b1;
          r.bypass_cap = 1'b1;
        end else begin
          // Reserved code: fall back to the supply so the converter never floats.
          r.supply = 1'b1;
        end
      end
    endcase
    return r;
  endfunction : decode_ref

  function automatic admrs_pkg::admrs_route_t decode_route(input logic [5:0] code);
    admrs_pkg::admrs_route_t r;
    r = '0;
    r.gain = admrs_pkg::GAIN_1X;
    if (code <= admrs_pkg::LAST_SE_CHAN) begin
      r.single_ended = 1'b1;
      r.pos = code[3:0];
    end else if (code == admrs_pkg::TEMP_CHAN) begin
      r.single_ended = 1'b1;
      r.temp_en = 1'b1;
      r.pos = admrs_pkg::TEMP_INPUT;
    end else begin
      r.differential = 1'b1;
      r.pos = {1'b0, code[2:0]};
      // The top code bit shorts both inputs to one pin so the stage reads its own offset.
      r.neg = code[5] ? {1'b0, code[2:0]} : {1'b0, 3'(code[2:0] + 3'h1)};
      r.gain = admrs_pkg::admrs_gain_t'(code[4:3]);
    end
    return r;
  endfunction : decode_route

  // ==========================================================================
  // Bus address phase capture.

  logic dp_valid_r;
  logic dp_write_r;
  logic [7:0] dp_addr_r;
  logic addr_phase;

  assign addr_phase = hsel_i && htrans_i[1] && hready_i;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_addr_r <= 8'h00;
    end else begin
      dp_valid_r <= addr_phase;
      dp_write_r <= hwrite_i;
      dp_addr_r <= haddr_i[7:0];
    end
  end

  logic wr_crr;
  logic wr_ctlb;
  logic wr_conv;

  always_comb begin
    wr_crr = 1'b0;
    wr_ctlb = 1'b0;
    wr_conv = 1'b0;
    if (!(dp_valid_r && dp_write_r)) begin
      wr_crr = 1'b0;
    end else if (dp_addr_r == admrs_pkg::CRR_ADDR) begin
      wr_crr = 1'b1;
    end else if (dp_addr_r == admrs_pkg::CTLB_ADDR) begin
      wr_ctlb = 1'b1;
    end else if (dp_addr_r == admrs_pkg::CONV_ADDR) begin
      wr_conv = 1'b1;
    end
  end

  // ==========================================================================
  // Software-visible select registers.

  logic [7:0] crr_r;
  logic [1:0] ctlb_r;
  logic [2:0] ref_code;
  logic [2:0] ref_code_nxt;
  logic [5:0] chan_code;

  assign ref_code = {ctlb_r[admrs_pkg::CTLB_REF_X_BIT], crr_r[admrs_pkg::CRR_REF_HI:admrs_pkg::CRR_REF_LO]};
  assign chan_code = {ctlb_r[admrs_pkg::CTLB_CHAN_X_BIT], crr_r[admrs_pkg::CRR_CHAN_HI:0]};

  always_comb begin
    ref_code_nxt = ref_code;
    if (wr_crr) begin
      ref_code_nxt[1:0] = hwdata_i[admrs_pkg::CRR_REF_HI:admrs_pkg::CRR_REF_LO];
    end
    if (wr_ctlb) begin
      ref_code_nxt[2] = hwdata_i[admrs_pkg::CTLB_REF_X_BIT];
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      crr_r <= admrs_pkg::CRR_RESET;
      ctlb_r <= admrs_pkg::CTLB_RESET;
    end else begin
      if (wr_crr) begin
        crr_r <= hwdata_i[7:0];
      end
      if (wr_ctlb) begin
        ctlb_r <= hwdata_i[1:0];
      end
    end
  end

  // ==========================================================================
  // Conversion sequencing.

  logic busy_r;
  logic done_r;
  logic long_pending_r;
  logic [CW-1:0] cnt_r;
  logic [admrs_pkg::RES_W-1:0] result_r;
  logic start;
  logic finish;

  assign start = wr_conv && hwdata_i[admrs_pkg::CONV_START_BIT] && !busy_r;
  assign finish = busy_r && (cnt_r == '0);

  // A start while busy is dropped; software polls the busy bit instead.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_r <= 1'b0;
      cnt_r <= '0;
    end else if (start) begin
      busy_r <= 1'b1;
      cnt_r <= long_pending_r ? EXTENDED_LOAD : NORMAL_LOAD;
    end else if (finish) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  // Any write that alters the reference code stretches the next conversion.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      long_pending_r <= 1'b0;
    end else if (ref_code_nxt != ref_code) begin
      long_pending_r <= 1'b1;
    end else if (start) begin
      long_pending_r <= 1'b0;
    end
  end

  // The done flag is cleared by writing one; a finish in the same cycle wins.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      done_r <= 1'b0;
    end else if (finish) begin
      done_r <= 1'b1;
    end else if (wr_conv && hwdata_i[admrs_pkg::CONV_DONE_BIT]) begin
      done_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      result_r <= '0;
    end else if (finish) begin
      result_r <= conv_result_i;
    end
  end

  // ==========================================================================
  // Active selection, frozen while a conversion runs.

  logic [2:0] act_ref_r;
  logic [5:0] act_chan_r;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      act_ref_r <= 3'h0;
      act_chan_r <= 6'h00;
    end else if (!busy_r) begin
      act_ref_r <= ref_code;
      act_chan_r <= chan_code;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ref_sel_o <= '0;
      route_o <= '0;
      converting_o <= 1'b0;
    end else begin
      ref_sel_o <= decode_ref(act_ref_r);
      route_o <= decode_route(act_chan_r);
      converting_o <= busy_r;
    end
  end

  // ==========================================================================
  // Read data, computed in the address phase so it is ready for the data phase.

  logic [15:0] result_view;
  logic [31:0] rd_nxt;
  logic [7:0] ra;

  // Alignment is applied on the read path so a justify write shows up at once.
  assign result_view = crr_r[admrs_pkg::CRR_JUST_BIT] ?
                       {result_r, 6'h00} : {6'h00, result_r};
  assign ra = haddr_i[7:0];

  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (!addr_phase || hwrite_i) begin
      rd_nxt = 32'h0000_0000;
    end else if (ra == admrs_pkg::CRR_ADDR) begin
      rd_nxt[7:0] = crr_r;
    end else if (ra == admrs_pkg::CTLB_ADDR) begin
      rd_nxt[1:0] = ctlb_r;
    end else if (ra == admrs_pkg::CONV_ADDR) begin
      rd_nxt[admrs_pkg::STAT_BUSY_BIT] = busy_r;
      rd_nxt[admrs_pkg::STAT_DONE_BIT] = done_r;
      rd_nxt[admrs_pkg::STAT_LONG_BIT] = long_pending_r;
      rd_nxt[admrs_pkg::STAT_REF_LO +: 3] = act_ref_r;
      rd_nxt[admrs_pkg::STAT_CHAN_LO +: 6] = act_chan_r;
    end else if (ra == admrs_pkg::RES_ADDR) begin
      rd_nxt[15:0] = result_view;
    end
  end

  // The slave never inserts wait states and always answers OKAY.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      hrdata_o <= rd_nxt;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

endmodule : admrs_top

// ==== testbench/admrs_assertions.sv ====
// Concurrent checks on the ports of the channel and reference select block.
`timescale 1ns/1ps
module admrs_chk #(
  parameter int NORMAL_CYCLES = 13,
  parameter int EXTENDED_CYCLES = 25
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_i,
  // Watched ports.
  input wire logic hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire admrs_pkg::admrs_ref_t ref_sel_o,
  input wire admrs_pkg::admrs_route_t route_o,
  input wire logic converting_o
);
  // ==========================================================================
  // Helpers.
  logic [7:0] run_r;
  logic rd_r;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) run_r <= 8'h00;
    else run_r <= converting_o ? run_r + 8'h01 : 8'h00;
  end
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) rd_r <= 1'b0;
    else rd_r <= hsel_i && htrans_i[1] && hready_i && !hwrite_i;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // The counter holds the span of the pulse at the edge where it is first seen low.
  sequence s_conv_end;
    converting_o ##1 !converting_o;
  endsequence
  // ==========================================================================
  // Properties.
  a_resp_okay: assert property (hresp_o == 1'b0 && hreadyout_o == 1'b1) else $error("bad response");
  a_rd_idle: assert property (!rd_r |-> hrdata_o == 32'h0) else $error("read data outside phase");
  a_conv_len: assert property (
    s_conv_end |-> (run_r == NORMAL_CYCLES || run_r == EXTENDED_CYCLES)) else $error("bad length");
  a_ref_hold: assert property (
    converting_o && $past(converting_o) |-> $stable(ref_sel_o)) else $error("reference moved");
  a_route_hold: assert property (
    converting_o && $past(converting_o) |-> $stable(route_o)) else $error("route moved");
  a_bypass_ref: assert property (
    ref_sel_o.bypass_cap |-> ref_sel_o.int_2v56) else $error("bypass without 2.56");
  a_ref_one: assert property ($onehot0(ref_sel_o[4:1])) else $error("two references");
  a_temp_route: assert property (
    route_o.temp_en |-> route_o.single_ended && route_o.pos == 4'hB) else $error("temp route");
  a_se_plain: assert property (
    route_o.single_ended |-> !route_o.differential && route_o.gain == admrs_pkg::GAIN_1X) else $error("se gain");
endmodule : admrs_chk

bind admrs_top admrs_chk #(.NORMAL_CYCLES(NORMAL_CYCLES), .EXTENDED_CYCLES(EXTENDED_CYCLES)) u_chk (
  .clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
  .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .ref_sel_o(ref_sel_o), .route_o(route_o), .converting_o(converting_o));

// ==== testbench/admrs_top_tb.sv ====
// Self-checking bench for the channel and reference select block.
`timescale 1ns/1ps
module admrs_top_tb;
  // ==========================================================================
  // Signals.
  localparam logic [7:0] A_CRR = admrs_pkg::CRR_ADDR;
  localparam logic [7:0] A_CTL = admrs_pkg::CTLB_ADDR;
  localparam logic [7:0] A_CNV = admrs_pkg::CONV_ADDR;
  localparam logic [7:0] A_RES = admrs_pkg::RES_ADDR;
  logic clk_i, reset_i, hsel_i, hwrite_i, rdp, hreadyout_o, hresp_o, converting_o;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, x, y;
  logic [1:0] htrans_i;
  logic [9:0] conv_result_i;
  logic [5:0] ch;
  admrs_pkg::admrs_ref_t ref_sel_o;
  admrs_pkg::admrs_route_t route_o;
  wire [8:0] rk = {route_o.single_ended, route_o.differential, route_o.temp_en, route_o.pos, route_o.gain};
  logic [31:0] seed = 32'h7B75;
  logic [31:0] expq[$];
  int num_errors = 0, num_checks = 0, run = 0, last_len = 0;

  // The lone slave's hreadyout is the bus hready.
  admrs_top uut (.clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .conv_result_i(conv_result_i), .ref_sel_o(ref_sel_o),
    .route_o(route_o), .converting_o(converting_o));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // ==========================================================================
  // Tasks.
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [4:0] ref_exp(input logic [2:0] c);
    case (c)
      3'h1, 3'h5: return 5'h08;
      3'h2: return 5'h04;
      3'h6: return 5'h02;
      3'h7: return 5'h03;
      default: return 5'h10;
    endcase
  endfunction : ref_exp
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %0t: value %h expected %h", $time, g, e);
    end
  endtask : chk
  task chk_rd(input logic [31:0] e);
    num_checks++;
    if (hrdata_o !== e) begin
      num_errors++;
      $display("Error %0t: read %h expected %h", $time, hrdata_o, e);
    end
  endtask : chk_rd
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    hsel_i <= 1'b1;
    haddr_i <= {24'h0, a};
    htrans_i <= 2'b10;
    hwrite_i <= w;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= d;
    rdp <= !w;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    rdp <= 1'b0;
  endtask : bus
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd
  // A register write reaches the select outputs two edges after its data phase ends.
  task settle();
    repeat (3) @(negedge clk_i);
  endtask : settle
  task wait_idle();
    while (converting_o !== 1'b1) @(negedge clk_i);
    while (converting_o === 1'b1) @(negedge clk_i);
    settle();
  endtask : wait_idle
  task stop_test();
    if (num_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  // ==========================================================================
  // Monitors.
  always @(posedge clk_i) begin
    if (rdp === 1'b1 && hreadyout_o === 1'b1) chk_rd(expq.pop_front());
  end
  always @(negedge clk_i) begin
    if (converting_o === 1'b1) run++;
    else if (run != 0) begin
      last_len = run;
      run = 0;
    end
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    stop_test();
  end

  // ==========================================================================
  // Scenarios.
  initial begin
    reset_i = 1'b1;
    {hsel_i, hwrite_i, rdp, htrans_i, haddr_i, hwdata_i, conv_result_i} = '0;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(A_CRR, 32'h0);
    rd(A_CTL, 32'h0);
    for (int c = 0; c < 8; c++) begin
      wr(A_CTL, {30'h0, c[2], 1'b0});
      wr(A_CRR, {24'h0, c[1:0], 6'h00});
      settle();
      chk(ref_sel_o, ref_exp(c[2:0]));
    end
    for (int c = 0; c < 13; c++) begin
      ch = (c == 12) ? 6'h25 : c[5:0];
      wr(A_CTL, {31'h0, ch[5]});
      wr(A_CRR, {27'h0, ch[4:0]});
      settle();
      chk(rk, {~ch[5], ch[5], ch == 6'h0B, ch[3:0], 2'b00});
      if (c == 12) chk(route_o.neg, 4'h5);
    end
    wr(A_CTL, 32'h0);
    wr(A_CRR, 32'h0);
    x = xs();
    conv_result_i <= x[9:0];
    wr(A_CNV, 32'h3);
    wr(A_CRR, 32'h4B);
    rd(A_CNV, 32'h5);
    settle();
    chk(ref_sel_o, 5'h10);
    wait_idle();
    chk(last_len, 25);
    rd(A_CNV, 32'hB16);
    rd(A_RES, {22'h0, x[9:0]});
    y = xs();
    conv_result_i <= y[9:0];
    wr(A_CNV, 32'h3);
    wr(A_CRR, 32'h6B);
    rd(A_RES, {16'h0, x[9:0], 6'h00});
    wait_idle();
    chk(last_len, 25);
    rd(A_RES, {16'h0, y[9:0], 6'h00});
    wr(A_CNV, 32'h3);
    wait_idle();
    chk(last_len, 13);
    rd(8'h30, 32'h0);
    stop_test();
  end
endmodule : admrs_top_tb
